/* rtl/rotate_subtract_skip_alu.sv */
// Purpose: Executes rotates, subtract with borrow, inc/dec skip and bit ops
// Assumes: Software loads operand, accumulator and flags, then writes go
// Notes: A taken skip holds discard_fetch for the dummy cycle
module rotate_subtract_skip_alu import alu_pkg::*; #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Sequencer side
  output logic busy,
  output logic discard_fetch
);
  state_t state_reg, state_next;
  op_t op_reg;
  logic [2:0] bit_sel_reg;
  logic [DATA_W-1:0] operand_reg, acc_reg;
  logic carry_flag_reg, half_carry_flag_reg, zero_flag_reg, signed_range_flag_reg;
  logic last_skip_reg;
  logic [1:0] last_cycles_reg;
  logic busy_reg, discard_fetch_reg;
  logic aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, read_word;
  logic read_hit, write_hit;
  logic wr_fire, lane0, go_write;
  logic [DATA_W-1:0] rot_result, add_a, add_b, add_sum;
  logic rot_carry, add_cin, add_carry, add_half, add_ovf;
  logic skip_cond, sum_zero;

  // Output ports straight from flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign busy = busy_reg;
  assign discard_fetch = discard_fetch_reg;

  // Write address capture, either order with data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (awvalid && awready_reg) begin
      aw_held_reg <= 1'b1;
      awready_reg <= 1'b0;
      awaddr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (!aw_held_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wvalid && wready_reg) begin
      w_held_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (!w_held_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // Write commit and decode
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign lane0 = wr_fire && wstrb_reg[0];
  assign write_hit = (awaddr_reg == OFS_CTRL) || (awaddr_reg == OFS_OPERAND) ||
                     (awaddr_reg == OFS_ACC) || (awaddr_reg == OFS_FLAGS) ||
                     (awaddr_reg == OFS_STATUS);
  assign go_write = lane0 && (awaddr_reg == OFS_CTRL) && wdata_reg[CTRL_GO_BIT] &&
                    (state_reg == ST_IDLE);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready && bvalid_reg) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    read_word = 32'h0000_0000;
    read_hit = 1'b1;
    case (araddr)
      OFS_CTRL: begin
        read_word[CTRL_OP_LSB +: 4] = op_reg;
        read_word[CTRL_BIT_LSB +: 3] = bit_sel_reg;
      end
      OFS_OPERAND: read_word[DATA_W-1:0] = operand_reg;
      OFS_ACC: read_word[DATA_W-1:0] = acc_reg;
      OFS_FLAGS: begin
        read_word[FLAG_C_BIT] = carry_flag_reg;
        read_word[FLAG_HALF_BIT] = half_carry_flag_reg;
        read_word[FLAG_Z_BIT] = zero_flag_reg;
        read_word[FLAG_RANGE_BIT] = signed_range_flag_reg;
      end
      OFS_STATUS: begin
        read_word[STAT_BUSY_BIT] = busy_reg;
        read_word[STAT_SKIP_BIT] = last_skip_reg;
        read_word[STAT_CYC_LSB +: 2] = last_cycles_reg;
      end
      default: read_hit = 1'b0;
    endcase
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= read_word;
      rresp_reg <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready && rvalid_reg) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // Datapath units
  rotate_unit #(.WIDTH(DATA_W)) u_rotate (
    .op(op_reg),
    .operand(operand_reg),
    .carry_in(carry_flag_reg),
    .result(rot_result),
    .carry_out(rot_carry)
  );

  // Adder inputs: borrow subtract, decrement or increment
  always_comb begin
    add_a = operand_reg;
    add_b = BYTE_ZERO;
    add_cin = 1'b1; // RQ11
    case (op_reg)
      OP_SUB_BORROW_ACC, OP_SUB_BORROW_MEM: begin
        add_a = acc_reg; // RQ6
        add_b = ~operand_reg;
        add_cin = carry_flag_reg;
      end
      OP_DEC_SKIP_ZERO, OP_DEC_ACC_SKIP_ZERO: begin
        add_b = BYTE_ALL_ONES; // RQ9
        add_cin = 1'b0;
      end
      default: begin
        add_b = BYTE_ZERO;
        add_cin = 1'b1;
      end
    endcase
  end

  add_flags_unit #(.WIDTH(DATA_W)) u_adder (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .carry_out(add_carry),
    .half_out(add_half),
    .ovf_out(add_ovf)
  );

  // Skip decision
  assign sum_zero = (add_sum == BYTE_ZERO);
  always_comb begin
    case (op_reg)
      OP_DEC_SKIP_ZERO, OP_DEC_ACC_SKIP_ZERO: skip_cond = sum_zero; // RQ9
      OP_INC_SKIP_ZERO, OP_INC_ACC_SKIP_ZERO: skip_cond = sum_zero; // RQ11
      OP_BIT_TEST_SKIP_SET: skip_cond = operand_reg[bit_sel_reg]; // RQ15
      default: skip_cond = 1'b0;
    endcase
  end

  // Sequencer state
  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = go_write ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_next = skip_cond ? ST_DUMMY : ST_IDLE; // RQ8
      ST_DUMMY: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      discard_fetch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next != ST_IDLE);
      discard_fetch_reg <= (state_next == ST_DUMMY); // RQ8
    end
  end

  // Instruction latch from control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_reg <= OP_NONE_F;
      bit_sel_reg <= 3'h0;
    end else if (lane0 && awaddr_reg == OFS_CTRL && state_reg == ST_IDLE) begin
      op_reg <= op_t'(wdata_reg[CTRL_OP_LSB +: 4]);
      bit_sel_reg <= wdata_reg[CTRL_BIT_LSB +: 3];
    end
  end

  // Memory operand: engine write-back wins over software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_reg <= OPERAND_RST;
    end else if (state_reg == ST_EXEC) begin
      case (op_reg)
        OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_THRU_CARRY: operand_reg <= rot_result; // RQ2 RQ4
        OP_SUB_BORROW_MEM: operand_reg <= add_sum; // RQ7
        OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: operand_reg <= add_sum; // RQ9 RQ11
        OP_BYTE_SET: operand_reg <= BYTE_ALL_ONES; // RQ13
        OP_BIT_SET: operand_reg[bit_sel_reg] <= 1'b1; // RQ14
        default: operand_reg <= operand_reg;
      endcase
    end else if (lane0 && awaddr_reg == OFS_OPERAND && state_reg == ST_IDLE) begin
      operand_reg <= wdata_reg[DATA_W-1:0];
    end
  end

  // Accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= ACC_RST;
    end else if (state_reg == ST_EXEC) begin
      case (op_reg)
        OP_ROT_LEFT_CARRY_ACC: acc_reg <= rot_result; // RQ1
        OP_ROTATE_RIGHT_ACC, OP_ROT_RIGHT_CARRY_ACC: acc_reg <= rot_result; // RQ3 RQ5
        OP_SUB_BORROW_ACC: acc_reg <= add_sum; // RQ6
        OP_DEC_ACC_SKIP_ZERO, OP_INC_ACC_SKIP_ZERO: acc_reg <= add_sum; // RQ10 RQ12
        default: acc_reg <= acc_reg;
      endcase
    end else if (lane0 && awaddr_reg == OFS_ACC && state_reg == ST_IDLE) begin
      acc_reg <= wdata_reg[DATA_W-1:0];
    end
  end

  // Status flags: rotates through carry touch carry only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_flag_reg <= 1'b0;
      half_carry_flag_reg <= 1'b0;
      zero_flag_reg <= 1'b0;
      signed_range_flag_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      case (op_reg)
        OP_ROT_LEFT_CARRY_ACC, OP_ROTATE_RIGHT_THRU_CARRY, OP_ROT_RIGHT_CARRY_ACC: begin
          carry_flag_reg <= rot_carry; // RQ1 RQ4 RQ5
        end
        OP_SUB_BORROW_ACC, OP_SUB_BORROW_MEM: begin
          carry_flag_reg <= add_carry; // RQ6 RQ7
          half_carry_flag_reg <= add_half;
          zero_flag_reg <= sum_zero;
          signed_range_flag_reg <= add_ovf;
        end
        default: carry_flag_reg <= carry_flag_reg;
      endcase
    end else if (lane0 && awaddr_reg == OFS_FLAGS && state_reg == ST_IDLE) begin
      carry_flag_reg <= wdata_reg[FLAG_C_BIT];
      half_carry_flag_reg <= wdata_reg[FLAG_HALF_BIT];
      zero_flag_reg <= wdata_reg[FLAG_Z_BIT];
      signed_range_flag_reg <= wdata_reg[FLAG_RANGE_BIT];
    end
  end

  // Outcome of last instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_skip_reg <= 1'b0;
      last_cycles_reg <= 2'h0;
    end else if (state_reg == ST_EXEC) begin
      last_skip_reg <= skip_cond;
      last_cycles_reg <= skip_cond ? CYC_SKIP : CYC_NO_SKIP; // RQ8
    end
  end

  // Checking helpers: previous-cycle view
  logic exec_d;
  op_t prev_op;
  logic [DATA_W-1:0] prev_opnd, prev_acc;
  logic [3:0] prev_flags;
  logic [2:0] prev_bit;
  logic [DATA_W:0] exp_sub;
  always_ff @(posedge aclk) begin
    exec_d <= aresetn && (state_reg == ST_EXEC);
    prev_op <= op_reg;
    prev_opnd <= operand_reg;
    prev_acc <= acc_reg;
    prev_bit <= bit_sel_reg;
    prev_flags <= {signed_range_flag_reg, zero_flag_reg, half_carry_flag_reg, carry_flag_reg};
  end
  assign exp_sub = {1'b0, prev_acc} + {1'b0, ~prev_opnd} + {{DATA_W{1'b0}}, prev_flags[0]};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_skip_taken;
    state_reg == ST_EXEC && skip_cond;
  endsequence
  sequence s_dummy_then_idle;
    state_reg == ST_DUMMY && discard_fetch_reg ##1 state_reg == ST_IDLE && !discard_fetch_reg;
  endsequence

  a_rotl_carry_acc: assert property (exec_d && prev_op == OP_ROT_LEFT_CARRY_ACC |->
    acc_reg == {prev_opnd[6:0], prev_flags[0]} && carry_flag_reg == prev_opnd[7] &&
    operand_reg == prev_opnd) else $error("left rotate through carry wrong"); // RQ1
  a_rotr_mem_only: assert property (exec_d && prev_op == OP_ROTATE_RIGHT |->
    operand_reg == {prev_opnd[0], prev_opnd[7:1]} && acc_reg == prev_acc &&
    carry_flag_reg == prev_flags[0]) else $error("right rotate wrong"); // RQ2
  a_rotr_acc_only: assert property (exec_d && prev_op == OP_ROTATE_RIGHT_ACC |->
    acc_reg == {prev_opnd[0], prev_opnd[7:1]} && operand_reg == prev_opnd &&
    carry_flag_reg == prev_flags[0]) else $error("right rotate to acc wrong"); // RQ3
  a_rotr_carry_mem: assert property (exec_d && prev_op == OP_ROTATE_RIGHT_THRU_CARRY |->
    operand_reg == {prev_flags[0], prev_opnd[7:1]} && carry_flag_reg == prev_opnd[0] &&
    zero_flag_reg == prev_flags[2]) else $error("right rotate thru carry wrong"); // RQ4
  a_rotr_carry_acc: assert property (exec_d && prev_op == OP_ROT_RIGHT_CARRY_ACC |->
    acc_reg == {prev_flags[0], prev_opnd[7:1]} && carry_flag_reg == prev_opnd[0] &&
    operand_reg == prev_opnd) else $error("right rotate carry to acc wrong"); // RQ5
  a_borrow_acc_flags: assert property (exec_d && prev_op == OP_SUB_BORROW_ACC |->
    {carry_flag_reg, acc_reg} == exp_sub && zero_flag_reg == (exp_sub[7:0] == 8'h00))
    else $error("subtract borrow to acc wrong"); // RQ6
  a_borrow_mem_flags: assert property (exec_d && prev_op == OP_SUB_BORROW_MEM |->
    {carry_flag_reg, operand_reg} == exp_sub && acc_reg == prev_acc)
    else $error("subtract borrow to mem wrong"); // RQ7
  a_skip_two_cycles: assert property (s_skip_taken |=> s_dummy_then_idle)
    else $error("skip did not insert one dummy cycle"); // RQ8
  a_noskip_one_cycle: assert property (state_reg == ST_EXEC && !skip_cond |=>
    state_reg == ST_IDLE && !discard_fetch_reg) else $error("no-skip took extra cycle"); // RQ8
  a_dec_mem_skip: assert property (exec_d && prev_op == OP_DEC_SKIP_ZERO |->
    operand_reg == prev_opnd - 8'h01 && discard_fetch_reg == (prev_opnd == 8'h01) &&
    prev_flags == {signed_range_flag_reg, zero_flag_reg, half_carry_flag_reg, carry_flag_reg})
    else $error("decrement skip wrong"); // RQ9
  a_dec_acc_skip: assert property (exec_d && prev_op == OP_DEC_ACC_SKIP_ZERO |->
    acc_reg == prev_opnd - 8'h01 && operand_reg == prev_opnd &&
    discard_fetch_reg == (prev_opnd == 8'h01)) else $error("decrement to acc wrong"); // RQ10
  a_inc_mem_skip: assert property (exec_d && prev_op == OP_INC_SKIP_ZERO |->
    operand_reg == prev_opnd + 8'h01 && discard_fetch_reg == (prev_opnd == 8'hFF) &&
    carry_flag_reg == prev_flags[0]) else $error("increment skip wrong"); // RQ11
  a_inc_acc_skip: assert property (exec_d && prev_op == OP_INC_ACC_SKIP_ZERO |->
    acc_reg == prev_opnd + 8'h01 && operand_reg == prev_opnd &&
    discard_fetch_reg == (prev_opnd == 8'hFF)) else $error("increment to acc wrong"); // RQ12
  a_byte_set_ones: assert property (exec_d && prev_op == OP_BYTE_SET |->
    operand_reg == 8'hFF && carry_flag_reg == prev_flags[0])
    else $error("byte set wrong"); // RQ13
  a_bit_set_one: assert property (exec_d && prev_op == OP_BIT_SET |->
    operand_reg == (prev_opnd | (8'h01 << prev_bit)))
    else $error("bit set wrong"); // RQ14
  a_bit_test_skip: assert property (exec_d && prev_op == OP_BIT_TEST_SKIP_SET |->
    discard_fetch_reg == prev_opnd[prev_bit] && operand_reg == prev_opnd)
    else $error("bit test skip wrong"); // RQ15
endmodule

/* rtl/alu_pkg.sv */
// Purpose: Shared constants and types for the rotate, subtract and skip datapath
// Assumes: 8-bit data; registers reached over a 32-bit AXI4-Lite slave
// Notes: Rules carried by the datapath follow
// Summary of operation
// RQ1 - Left rotate through carry to accumulator; old carry to bit 0, bit 7 to carry
// RQ2 - Plain right rotate of memory, bit 0 into bit 7, flags kept
// RQ3 - Right rotate to accumulator, memory and flags kept
// RQ4 - Nine-bit right rotate with carry, written back to memory, only carry changes
// RQ5 - Nine-bit right rotate to accumulator, carry from operand bit 0, memory kept
// RQ6 - Accumulator plus inverted operand plus carry into accumulator, four flags updated
// RQ7 - Same subtract-with-borrow sum written to memory, four flags updated
// RQ8 - A taken skip adds one dummy cycle: two cycles, otherwise one
// RQ9 - Decrement memory, write back, skip on zero, no flag changes
// RQ10 - Operand minus one to accumulator, memory kept, skip on zero, no flags
// RQ11 - Increment memory, write back, skip on zero, no flag changes
// RQ12 - Operand plus one to accumulator, memory kept, skip on zero, no flags
// RQ13 - Byte set writes all ones to memory, flags unchanged
// RQ14 - Bit set forces the selected bit to one, others and flags kept
// RQ15 - Bit test skips when the selected bit is one, operand and flags kept
package alu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BIT_LSB = 4;
  localparam int CTRL_GO_BIT = 7;
  // Flag fields
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_HALF_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_RANGE_BIT = 3;
  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int STAT_CYC_LSB = 2;
  // Reset values and constants
  localparam logic [7:0] OPERAND_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Instruction lengths in cycles
  localparam logic [1:0] CYC_NO_SKIP = 2'h1;
  localparam logic [1:0] CYC_SKIP = 2'h2;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_ROT_LEFT_CARRY_ACC = 4'b0000,
    OP_ROTATE_RIGHT = 4'b0001,
    OP_ROTATE_RIGHT_ACC = 4'b0010,
    OP_ROTATE_RIGHT_THRU_CARRY = 4'b0011,
    OP_ROT_RIGHT_CARRY_ACC = 4'b0100,
    OP_SUB_BORROW_ACC = 4'b0101,
    OP_SUB_BORROW_MEM = 4'b0110,
    OP_DEC_SKIP_ZERO = 4'b0111,
    OP_DEC_ACC_SKIP_ZERO = 4'b1000,
    OP_INC_SKIP_ZERO = 4'b1001,
    OP_INC_ACC_SKIP_ZERO = 4'b1010,
    OP_BYTE_SET = 4'b1011,
    OP_BIT_SET = 4'b1100,
    OP_BIT_TEST_SKIP_SET = 4'b1101,
    OP_NONE_E = 4'b1110,
    OP_NONE_F = 4'b1111
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DUMMY = 2'b10
  } state_t;
endpackage

/* rtl/rotate_unit.sv */
// Purpose: Single-step rotate network, plain and through carry
// Assumes: Pure combinational; caller picks where the result lands
// Notes: Non-rotate opcodes pass the operand and carry unchanged
module rotate_unit import alu_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Operation select
  input wire op_t op,
  // Operand and carry in
  input wire logic [WIDTH-1:0] operand,
  input wire logic carry_in,
  // Rotated value and carry out
  output logic [WIDTH-1:0] result,
  output logic carry_out
);
  // Rotate selection
  always_comb begin
    result = operand;
    carry_out = carry_in;
    case (op)
      OP_ROT_LEFT_CARRY_ACC: begin
        result = {operand[WIDTH-2:0], carry_in}; // RQ1
        carry_out = operand[WIDTH-1];
      end
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_ACC: begin
        result = {operand[0], operand[WIDTH-1:1]}; // RQ2
      end
      OP_ROTATE_RIGHT_THRU_CARRY, OP_ROT_RIGHT_CARRY_ACC: begin
        result = {carry_in, operand[WIDTH-1:1]}; // RQ4
        carry_out = operand[0];
      end
      default: begin
        result = operand;
        carry_out = carry_in;
      end
    endcase
  end
endmodule

/* rtl/add_flags_unit.sv */
// Purpose: Adder with carry in producing carry, half carry and overflow
// Assumes: Pure combinational; subtract is done by inverting b outside
// Notes: Half carry is the carry out of bit 3
module add_flags_unit #(
  parameter int WIDTH = 8
) (
  // Addends
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  // Sum and flags
  output logic [WIDTH-1:0] sum,
  output logic carry_out,
  output logic half_out,
  output logic ovf_out
);
  logic [WIDTH:0] full;
  logic [4:0] low;

  // Full and low-nibble sums
  assign full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign sum = full[WIDTH-1:0];
  assign carry_out = full[WIDTH];
  assign half_out = low[4];
  // Same-sign addends giving a different-sign sum
  assign ovf_out = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]);
endmodule

/* test/alu_host_model.sv */
// Purpose: Sequencer-side register master for the datapath
// Assumes: One write and one read at most under way
// Notes: Released address and data lines show the inverse of their last value
module alu_host_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, wstrb, araddr} = '0;
  // Write: address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'h7, a, d, 4'hF};
    do begin
      @(posedge aclk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    do begin
      @(posedge aclk);
      if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
    end while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
endmodule

/* test/rotate_subtract_skip_alu_tb_top.sv */
// Purpose: Self-checking bench against an integer model of every opcode
// Assumes: Registers loaded over the bus, results read back after busy drops
// Notes: Busy and discard cycles counted at every rising edge by a monitor
module rotate_subtract_skip_alu_tb_top import alu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic busy, discard_fetch;
  logic [7:0] awaddr, araddr, seed = 8'h18;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int bad_count = 0, cmp_count = 0, busy_tot = 0, disc_tot = 0, m;
  always #10 aclk = ~aclk;
  rotate_subtract_skip_alu dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .busy, .discard_fetch);
  alu_host_model host_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp);
  // Busy and discard cycle totals
  always @(posedge aclk) begin
    busy_tot <= busy_tot + (busy === 1'b1 ? 1 : 0);
    disc_tot <= disc_tot + (discard_fetch === 1'b1 ? 1 : 0);
  end
  function automatic int nxt();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return int'(seed);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    chk(nm, {30'h0, e}, {30'h0, g});
  endtask
  task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    host_u.rd(ad, rd_val, resp);
    chk_resp("rresp", RESP_OKAY, resp);
    chk(nm, e, rd_val);
  endtask
  // Load state, fire one opcode, compare with the model
  task automatic run(input int op, input int bt, input int m, input int a, input int f);
    int s, c, sk, b0, d0;
    host_u.wr(OFS_OPERAND, m, resp);
    host_u.wr(OFS_ACC, a, resp);
    host_u.wr(OFS_FLAGS, f, resp);
    c = f & 1;
    sk = 0;
    case (op)
      0: begin a = ((m << 1) | c) & 255; f = (f & 14) | (m >> 7); end
      1: m = ((m >> 1) | (m << 7)) & 255;
      2: a = ((m >> 1) | (m << 7)) & 255;
      3: begin f = (f & 14) | (m & 1); m = (m >> 1) | (c << 7); end
      4: begin f = (f & 14) | (m & 1); a = (m >> 1) | (c << 7); end
      5, 6: begin
        s = a + (~m & 255) + c;
        f = (s > 255 ? 1 : 0) | ((a & 15) + (~m & 15) + c > 15 ? 2 : 0);
        f |= ((s & 255) == 0 ? 4 : 0) | (((a ^ s) & (~m ^ s) & 128) != 0 ? 8 : 0);
        if (op == 5) a = s & 255;
        else m = s & 255;
      end
      7: begin m = (m + 255) & 255; sk = m == 0; end
      8: begin a = (m + 255) & 255; sk = a == 0; end
      9: begin m = (m + 1) & 255; sk = m == 0; end
      10: begin a = (m + 1) & 255; sk = a == 0; end
      11: m = BYTE_ALL_ONES;
      12: m = m | (1 << bt);
      13: sk = (m >> bt) & 1;
      default: ;
    endcase
    {b0, d0} = {busy_tot, disc_tot};
    host_u.wr(OFS_CTRL, 128 | (bt << 4) | op, resp);
    chk_resp("bresp", RESP_OKAY, resp);
    do host_u.rd(OFS_STATUS, rd_val, resp); while (rd_val[0] !== 1'b0);
    chk("busy_cycles", 1 + sk, busy_tot - b0);
    chk("discard_cycles", sk, disc_tot - d0);
    rdchk("operand", OFS_OPERAND, m);
    rdchk("acc", OFS_ACC, a);
    rdchk("flags", OFS_FLAGS, f);
    rdchk("status", OFS_STATUS, {28'h0, sk ? CYC_SKIP : CYC_NO_SKIP, sk[0], 1'b0});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset, reset values, unmapped place, then every opcode three times
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk("operand_rst", OFS_OPERAND, OPERAND_RST);
    rdchk("acc_rst", OFS_ACC, ACC_RST);
    rdchk("flags_rst", OFS_FLAGS, 0);
    host_u.rd(8'h14, rd_val, resp);
    chk_resp("unmapped_rd", RESP_SLVERR, resp);
    chk("unmapped_rdata", 0, rd_val);
    host_u.wr(8'h14, 32'h0000_00FF, resp);
    chk_resp("unmapped_wr", RESP_SLVERR, resp);
    for (int r = 0; r < 3; r++)
      for (int op = 0; op < 16; op++) begin
        m = (r == 0 && op inside {7, 8}) ? 1 : (r == 0 && op inside {9, 10, 13}) ? 255 : nxt();
        run(op, nxt() & 7, m, nxt(), nxt() & 15);
      end
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule
